// >>> logic/read_sync_consts.svh
// Constants for the read synchroniser sequencing block.
`ifndef READ_SYNC_CONSTS_SVH
`define READ_SYNC_CONSTS_SVH

// Read pulses to wait after the freeze before restarting on read data.
`define RESTART_READ_EDGES   2'd2
// Most reference cycles between read-select release and the restart.
`define RESTART_REF_CYCLES   3'd4
// Consecutive matching pulses needed before preamble is declared.
`define MATCH_LEN_SHORT      6'd32
`define MATCH_LEN_4T         6'd16
// Reference rising edges per frequency comparison window.
`define OFFSET_WINDOW        8'd16
// Oscillator counts below and above which a correction is requested.
`define OFFSET_LOW_LIMIT     9'd8
`define OFFSET_HIGH_LIMIT    9'd24
// Sync pattern select code of the 4T pattern.
`define PATTERN_4T           2'b11
// Divider and spacing counter value while held.
`define DIV_HOLD_COUNT       3'd0

`endif

// >>> logic/read_sync_pkg.sv
// Types for the read synchroniser sequencing block.
package read_sync_pkg;
    typedef enum logic [2:0] {
        REF_RUN,
        FREEZE_READ,
        READ_RUN,
        FREEZE_REF
    } seq_state_t;
    typedef logic [1:0] pattern_sel_t;
endpackage

// >>> logic/read_sync_preamble_control.sv
// Restart sequencing, matching divider, preamble detector, offset clamp, clock mux.
`timescale 1ns/1ps
`include "read_sync_consts.svh"

module read_sync_preamble_control
    import read_sync_pkg::*;
#(
    parameter int MATCH_W = 6
) (
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       reset_n_i,
    // Drive controller
    input  wire logic                       read_select_i,
    input  wire logic                       freq_acquire_n_i,
    input  wire read_sync_pkg::pattern_sel_t pattern_sel_i,
    // Read channel and clock sources, sampled levels
    input  wire logic                       raw_read_pulses_i,
    input  wire logic                       ref_clk_i,
    input  wire logic                       vco_clk_i,
    // Loop control
    output logic                            comparator_clear_o,
    output logic                            vco_freeze_o,
    output logic                            divider_in_path_o,
    output logic                            divider_pulse_o,
    output logic                            pump_up_o,
    output logic                            pump_down_o,
    // Status and recovered clock
    output logic                            restart_done_o,
    output logic                            preamble_found_o,
    output logic                            recovered_clk_o
);
    import read_sync_pkg::*;

    if (MATCH_W < 6) begin : g_chk
        $error("MATCH_W must hold a count of 32");
    end

    // ****************************************************
    // Edge detection
    // ****************************************************
    logic rs_d, rp_d, ref_d, vco_d;
    wire  rs_edge   = read_select_i ^ rs_d;
    wire  rp_rise   = raw_read_pulses_i & ~rp_d;
    wire  ref_rise  = ref_clk_i & ~ref_d;
    wire  vco_rise  = vco_clk_i & ~vco_d;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rs_d  <= 1'b0;
            rp_d  <= 1'b0;
            ref_d <= 1'b0;
            vco_d <= 1'b0;
        end else begin
            rs_d  <= read_select_i;
            rp_d  <= raw_read_pulses_i;
            ref_d <= ref_clk_i;
            vco_d <= vco_clk_i;
        end
    end

    // Modulus minus one: 00 gives 0 up to 11 gives 3, so moduli 1 to 4.
    function automatic logic [2:0] modulus_last(input pattern_sel_t sel);
        return {1'b0, sel};
    endfunction

    // ****************************************************
    // Restart sequencer
    // ****************************************************
    seq_state_t state, next_state;
    logic [1:0] pulse_cnt, next_pulse_cnt;
    logic [2:0] ref_cnt, next_ref_cnt;
    logic       ref_half;

    wire frozen      = (state == FREEZE_READ) || (state == FREEZE_REF);
    wire reading     = (state == READ_RUN);
    // Reference halved: restart on the rising edge of the divided clock.
    wire ref_half_up = ref_rise & ~ref_half;

    always_comb begin
        next_state     = state;
        next_pulse_cnt = pulse_cnt;
        next_ref_cnt   = ref_cnt;
        if (rs_edge) begin
            next_state     = read_select_i ? FREEZE_READ : FREEZE_REF;
            next_pulse_cnt = 2'd0;
            next_ref_cnt   = 3'd0;
        end else begin
            unique case (state)
                REF_RUN: ;
                READ_RUN: ;
                FREEZE_READ: begin
                    if (rp_rise) begin
                        next_pulse_cnt = pulse_cnt + 2'd1;
                        if (pulse_cnt + 2'd1 == `RESTART_READ_EDGES) begin
                            next_state = READ_RUN;
                        end
                    end
                end
                // bounded wait for the halved reference
                FREEZE_REF: begin
                    if (ref_rise) begin
                        next_ref_cnt = ref_cnt + 3'd1;
                    end
                    if (ref_half_up || (ref_rise && ref_cnt + 3'd1 == `RESTART_REF_CYCLES)) begin
                        next_state = REF_RUN;
                    end
                end
                default: next_state = REF_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state     <= REF_RUN;
            pulse_cnt <= 2'd0;
            ref_cnt   <= 3'd0;
            ref_half  <= 1'b0;
        end else begin
            state     <= next_state;
            pulse_cnt <= next_pulse_cnt;
            ref_cnt   <= next_ref_cnt;
            if (ref_rise) begin
                ref_half <= ~ref_half;
            end
        end
    end

    // ****************************************************
    // Matching divider
    // ****************************************************
    logic [2:0] div_cnt;
    wire  [2:0] div_last = modulus_last(pattern_sel_i);
    // divider sits in the feedback path only while acquiring in a read
    wire        div_path = reading & ~freq_acquire_n_i;
    wire        div_wrap = vco_rise && (div_cnt >= div_last);

    // held until restart completes; restart resets it
    // a later acquire reuses the running count, phase not realigned
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt <= `DIV_HOLD_COUNT;
        end else if (!reading) begin
            div_cnt <= `DIV_HOLD_COUNT;
        end else if (vco_rise) begin
            div_cnt <= div_wrap ? `DIV_HOLD_COUNT : div_cnt + 3'd1;
        end
    end

    // ****************************************************
    // Preamble pattern detector
    // ****************************************************
    logic [2:0]       gap_cnt;
    logic [MATCH_W-1:0] match_cnt;
    // spacing expected of the selected pattern, in oscillator periods
    wire        gap_ok     = (gap_cnt == div_last);
    wire [MATCH_W-1:0] match_need = (pattern_sel_i == `PATTERN_4T) ?
                                    MATCH_W'(`MATCH_LEN_4T) : MATCH_W'(`MATCH_LEN_SHORT);
    wire        match_hit  = rp_rise && gap_ok && (match_cnt + 1'b1 >= match_need);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_cnt   <= 3'd0;
            match_cnt <= '0;
        end else if (!reading) begin
            // no search before the read restart has finished
            gap_cnt   <= 3'd0;
            match_cnt <= '0;
        end else if (rp_rise) begin
            gap_cnt   <= 3'd0;
            // a wrong spacing starts the count again
            match_cnt <= gap_ok ? match_cnt + 1'b1 : '0;
        end else if (vco_rise && gap_cnt != 3'h7) begin
            gap_cnt <= gap_cnt + 3'd1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            preamble_found_o <= 1'b0;
        end else if (!read_select_i) begin
            preamble_found_o <= 1'b0;
        end else if (match_hit) begin
            // flag on enough pulses; held until read-select drops
            preamble_found_o <= 1'b1;
        end
    end

    // ****************************************************
    // Frequency offset clamp
    // ****************************************************
    logic [7:0] win_cnt;
    logic [8:0] vco_cnt;
    wire        win_end = ref_rise && (win_cnt == `OFFSET_WINDOW - 8'd1);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            win_cnt     <= 8'd0;
            vco_cnt     <= 9'd0;
            pump_up_o   <= 1'b0;
            pump_down_o <= 1'b0;
        end else begin
            if (ref_rise) begin
                win_cnt <= win_end ? 8'd0 : win_cnt + 8'd1;
            end
            if (win_end) begin
                vco_cnt     <= 9'd0;
                // oscillator under half the reference rate
                pump_up_o   <= vco_cnt < `OFFSET_LOW_LIMIT;
                // oscillator over one and a half times the reference
                pump_down_o <= vco_cnt > `OFFSET_HIGH_LIMIT;
            end else if (vco_rise && vco_cnt != 9'h1FF) begin
                vco_cnt <= vco_cnt + 9'd1;
            end
        end
    end

    // ****************************************************
    // Recovered clock multiplexer
    // ****************************************************
    logic src_vco;
    wire  want_vco = reading;
    wire  want_lvl = want_vco ? vco_clk_i : ref_clk_i;
    // swap only while output and new source are both high
    wire  swap_ok  = (want_vco != src_vco) && recovered_clk_o && want_lvl;
    wire  next_src = swap_ok ? want_vco : src_vco;

    // a frozen oscillator rests high, so no runt pulse leaves
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            src_vco         <= 1'b0;
            recovered_clk_o <= 1'b0;
        end else begin
            src_vco         <= next_src;
            recovered_clk_o <= next_src ? (vco_clk_i | frozen) : ref_clk_i;
        end
    end

    // ****************************************************
    // Registered loop control outputs
    // ****************************************************
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            comparator_clear_o <= 1'b0;
            vco_freeze_o       <= 1'b0;
            divider_in_path_o  <= 1'b0;
            divider_pulse_o    <= 1'b0;
            restart_done_o     <= 1'b1;
        end else begin
            // freeze held until restart on the newly chosen input
            comparator_clear_o <= (next_state == FREEZE_READ) || (next_state == FREEZE_REF);
            vco_freeze_o       <= (next_state == FREEZE_READ) || (next_state == FREEZE_REF);
            // From the next state, so the path drops together with restart_done_o.
            divider_in_path_o  <= (next_state == READ_RUN) && !freq_acquire_n_i;
            divider_pulse_o    <= div_path ? div_wrap : vco_rise;
            restart_done_o     <= (next_state == READ_RUN) || (next_state == REF_RUN);
        end
    end

endmodule

// >>> bench/read_sync_preamble_control_asserts.sv
// Port-level checks for the read synchroniser sequencing block.
`timescale 1ns/1ps
module read_sync_preamble_control_asserts
    import read_sync_pkg::*;
(
    // Inputs of the block
    input wire logic         sys_clk_i,
    input wire logic         reset_n_i,
    input wire logic         read_select_i,
    input wire logic         freq_acquire_n_i,
    input wire pattern_sel_t pattern_sel_i,
    input wire logic         raw_read_pulses_i,
    input wire logic         ref_clk_i,
    input wire logic         vco_clk_i,
    // Outputs of the block
    input wire logic         comparator_clear_o,
    input wire logic         vco_freeze_o,
    input wire logic         divider_in_path_o,
    input wire logic         divider_pulse_o,
    input wire logic         pump_up_o,
    input wire logic         pump_down_o,
    input wire logic         restart_done_o,
    input wire logic         preamble_found_o,
    input wire logic         recovered_clk_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_freeze_pair: assert property (vco_freeze_o == comparator_clear_o)
        else $error("freeze and clear differ");
    a_edge_freeze: assert property ($changed(read_select_i) |=> comparator_clear_o)
        else $error("no freeze after read select edge");
    a_done_frozen: assert property (restart_done_o != vco_freeze_o)
        else $error("restart done while frozen");
    a_path_cause: assert property (divider_in_path_o |-> restart_done_o && !$past(freq_acquire_n_i))
        else $error("divider in path without acquire");
    a_found_hold: assert property (preamble_found_o && read_select_i |=> preamble_found_o)
        else $error("preamble flag dropped during read");
    a_found_clear: assert property (!read_select_i |=> !preamble_found_o)
        else $error("preamble flag kept after read");
    a_found_run: assert property ($rose(preamble_found_o) |-> restart_done_o && $past(read_select_i))
        else $error("preamble flag outside read run");
    a_up_steady: assert property ($changed(pump_up_o) |=> $stable(pump_up_o) [*8])
        else $error("pump up changed inside a window");
    a_down_steady: assert property ($changed(pump_down_o) |=> $stable(pump_down_o) [*8])
        else $error("pump down changed inside a window");
    a_pulse_single: assert property (divider_pulse_o |=> !divider_pulse_o)
        else $error("divider pulse longer than one cycle");
    a_ref_follow: assert property (!read_select_i && !$past(read_select_i, 64) && restart_done_o
        && $past(reset_n_i, 2) |-> recovered_clk_o == $past(ref_clk_i))
        else $error("output clock does not follow reference");
endmodule

bind read_sync_preamble_control read_sync_preamble_control_asserts chk_u (.*);

// >>> bench/read_channel_model.sv
// Read channel and clock sources feeding the block, driven on the falling edge.
`timescale 1ns/1ps
module read_channel_model #(
    parameter int REF_HALF = 4
) (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] vco_half_i,
    input  wire logic [7:0] spacing_i,
    input  wire logic       pulse_en_i,
    input  wire logic       break_i,
    output logic            ref_clk_o,
    output logic            vco_clk_o,
    output logic            pulse_o,
    output int              pulse_cnt_o,
    output int              vco_rises_o
);
    int ref_t;
    int vco_t;
    int gap;
    logic fire;
    initial begin
        {ref_clk_o, vco_clk_o, pulse_o, ref_t, vco_t, gap, pulse_cnt_o, vco_rises_o} = '0;
    end
    // Pulses land on an oscillator rise; a break stretches one gap by a period.
    always @(negedge sys_clk_i) begin
        fire = 1'b0;
        ref_t = ref_t + 1;
        vco_t = vco_t + 1;
        if (ref_t >= REF_HALF) begin
            ref_t = 0;
            ref_clk_o <= ~ref_clk_o;
        end
        if (vco_t >= vco_half_i) begin
            vco_t = 0;
            vco_clk_o <= ~vco_clk_o;
            if (!vco_clk_o) begin
                vco_rises_o <= vco_rises_o + 1;
                gap = gap + 1;
                if (pulse_en_i && gap >= spacing_i + break_i) begin
                    gap = 0;
                    fire = 1'b1;
                    pulse_cnt_o <= pulse_cnt_o + 1;
                end
            end
        end
        pulse_o <= fire;
    end
endmodule

// >>> bench/read_sync_preamble_control_tb_top.sv
// Sequence tests for the read synchroniser sequencing block.
`timescale 1ns/1ps
module read_sync_preamble_control_tb_top;
    import read_sync_pkg::*;
    logic sys_clk = 0, reset_n = 0, rd = 0, acq_n = 1, pen = 0, brk = 0;
    pattern_sel_t sel = 2'h0;
    logic [7:0] vh = 8'h04, sp = 8'h01;
    logic rp, rc, vc, clr, frz, path, dp, pu, pd, done, found, rclk;
    int pcnt, vr, dcnt = 0, fails = 0, n_checks = 0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (dp === 1'b1) dcnt++;
    read_channel_model ch_u (.sys_clk_i(sys_clk), .vco_half_i(vh), .spacing_i(sp),
        .pulse_en_i(pen), .break_i(brk), .ref_clk_o(rc), .vco_clk_o(vc), .pulse_o(rp),
        .pulse_cnt_o(pcnt), .vco_rises_o(vr));
    read_sync_preamble_control dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .read_select_i(rd), .freq_acquire_n_i(acq_n), .pattern_sel_i(sel),
        .raw_read_pulses_i(rp), .ref_clk_i(rc), .vco_clk_i(vc), .comparator_clear_o(clr),
        .vco_freeze_o(frz), .divider_in_path_o(path), .divider_pulse_o(dp), .pump_up_o(pu),
        .pump_down_o(pd), .restart_done_o(done), .preamble_found_o(found),
        .recovered_clk_o(rclk));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string w, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic chk_near(input string w, input int e, input int g, input int tol);
        n_checks++;
        if (g < e - tol || g > e + tol) begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", w, e, g);
        end
    endtask
    task automatic wait_done(input int lim);
        int i;
        for (i = 0; i < lim && done !== 1'b1; i++) @(negedge sys_clk);
        if (done !== 1'b1) begin
            chk("restart_done", 1'b1, done);
            close_out();
        end
    endtask
    task automatic wait_pulses(input int n);
        int t;
        int i;
        t = pcnt + n;
        for (i = 0; i < 20000 && pcnt < t; i++) @(negedge sys_clk);
        if (pcnt < t) begin
            chk_near("pulse count", t, pcnt, 0);
            close_out();
        end
    endtask
    task automatic start_read(input pattern_sel_t s, input logic [7:0] spacing);
        int p;
        sel = s;
        sp = spacing;
        pen = 1'b1;
        wait_pulses(1);
        rd = 1'b1;
        p = pcnt;
        @(negedge sys_clk);
        chk("freeze", 1'b1, frz);
        chk("clear", 1'b1, clr);
        wait_done(4000);
        chk_near("pulses to restart", 2, pcnt - p, 0);
    endtask
    task automatic end_read();
        rd = 1'b0;
        @(negedge sys_clk);
        chk("freeze", 1'b1, frz);
        wait_done(36);
        @(negedge sys_clk);
        chk("found", 1'b0, found);
        chk("path", 1'b0, path);
    endtask
    initial begin
        int d0;
        int v0;
        int need;
        repeat (10) @(negedge sys_clk);
        chk("done", 1'b1, done);
        chk("found", 1'b0, found);
        reset_n = 1'b1;
        acq_n = 1'b0;
        for (int s = 0; s < 4; s++) begin
            start_read(s[1:0], 8'(s + 1));
            @(negedge sys_clk);
            chk("path", 1'b1, path);
            need = (s == 3) ? 16 : 32;
            wait_pulses(need - 10);
            chk("found early", 1'b0, found);
            wait_pulses(16);
            chk("found", 1'b1, found);
            d0 = dcnt;
            v0 = vr;
            for (int i = 0; i < 2000 && vr - v0 < 24; i++) @(negedge sys_clk);
            chk_near("vco rises", 24, vr - v0, 0);
            if (vr - v0 < 24) close_out();
            chk_near("divider pulses", 24 / (s + 1), dcnt - d0, 1);
            acq_n = found;
            repeat (2) @(negedge sys_clk);
            chk("path off", 1'b0, path);
            acq_n = 1'b0;
            repeat (2) @(negedge sys_clk);
            chk("path again", 1'b1, path);
            end_read();
        end
        start_read(2'h1, 8'h02);
        wait_pulses(20);
        brk = 1'b1;
        wait_pulses(1);
        brk = 1'b0;
        wait_pulses(20);
        chk("found after break", 1'b0, found);
        wait_pulses(20);
        chk("found", 1'b1, found);
        end_read();
        vh = 8'h05;
        start_read(2'h0, 8'h02);
        wait_pulses(40);
        chk("found wrong kind", 1'b0, found);
        chk("clock out", vc, rclk);
        end_read();
        pen = 1'b0;
        vh = 8'h0A;
        repeat (300) @(negedge sys_clk);
        chk("pump up", 1'b1, pu);
        chk("pump down", 1'b0, pd);
        chk("clock out", rc, rclk);
        vh = 8'h02;
        repeat (300) @(negedge sys_clk);
        chk("pump down", 1'b1, pd);
        chk("pump up", 1'b0, pu);
        vh = 8'h04;
        repeat (300) @(negedge sys_clk);
        chk("pump down", 1'b0, pd);
        chk("pump up", 1'b0, pu);
        close_out();
    end
endmodule
